// ==== core/cpm_power_manager.sv ====
`timescale 1ns/10ps
module cpm_power_manager
  import cpm_pkg::*;
#(
  parameter int NP = NUM_PERIPH,
  parameter logic [DIV_W-1:0] SYS_DIV = SYS_DIV_DEF,
  parameter logic [DIV_W-1:0] PER_DIV = PER_DIV_DEF
) (
  // phase-locked loop clock and reset
  input wire logic clk,
  input wire logic rstn,
  // mode control from software
  input wire logic mode_wr,
  input wire cpm_mode_t mode_sel,
  input wire logic [SLOW_W-1:0] slow_clock_setting,
  input wire logic [NP-1:0] periph_clk_on,
  // wake sources
  input wire logic cpu_irq,
  input wire logic wake_evt,
  // clocks out
  output logic cpu_core_clock,
  output logic sys_bus_clock,
  output logic periph_bus_clock,
  output logic [NP-1:0] periph_clk,
  // status
  output cpm_mode_t mode_state,
  output cpm_clk_en_t clk_en,
  output logic [NP-1:0] periph_en,
  output logic pll_bypass
);

  cpm_mode_t mode_r, mode_nxt;
  cpm_clk_en_t en_r, en_nxt;
  logic [NP-1:0] periph_en_r;
  logic [SLOW_W-1:0] slow_cnt_r;
  logic slow_tick;
  logic [1:0] div_tick;
  logic wake_meta_r, wake_sync_r;
  logic pll_bypass_r;

  function automatic logic cnt_zero(input logic [DIV_W-1:0] c);
    cnt_zero = (c == DIV_CNT_RST);
  endfunction

  // wake pin synchroniser, on the free-running clock so it keeps working in sleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_meta_r <= 1'h0;
      wake_sync_r <= 1'h0;
    end else begin
      wake_meta_r <= wake_evt;
      wake_sync_r <= wake_meta_r; // R7
    end
  end

  // mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      CPM_NORMAL, CPM_SLOW: begin
        if (mode_wr) begin
          mode_nxt = mode_sel; // R8
        end
      end
      CPM_IDLE: begin
        if (cpu_irq || wake_sync_r) begin
          mode_nxt = CPM_NORMAL; // R6
        end
      end
      CPM_SLEEP: begin
        if (wake_sync_r) begin
          mode_nxt = CPM_NORMAL; // R8
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // slow core clock divider, restarted whenever slow mode is left
  assign slow_tick = (slow_cnt_r == SLOW_CNT_RST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slow_cnt_r <= SLOW_CNT_RST;
    end else if (mode_r != CPM_SLOW) begin
      slow_cnt_r <= SLOW_CNT_RST;
    end else if (slow_tick) begin
      slow_cnt_r <= slow_clock_setting; // R4
    end else begin
      slow_cnt_r <= slow_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_bypass_r <= 1'h0;
    end else begin
      pll_bypass_r <= (mode_r == CPM_SLOW); // R4
    end
  end

  // bus clock dividers, both counting the one loop clock
  generate
    for (genvar i = 0; i < 2; i++) begin : g_div
      localparam logic [DIV_W-1:0] RATIO = (i == 0) ? SYS_DIV : PER_DIV;
      logic [DIV_W-1:0] cnt_r;
      assign div_tick[i] = cnt_zero(cnt_r);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_r <= DIV_CNT_RST;
        end else if (div_tick[i]) begin
          cnt_r <= RATIO; // R1
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  endgenerate

  // gate enables per mode
  always_comb begin
    en_nxt.core = (mode_r == CPM_NORMAL) || ((mode_r == CPM_SLOW) && slow_tick); // R2 R4 R5
    en_nxt.sys = (mode_r != CPM_SLEEP) && div_tick[0]; // R5 R7
    en_nxt.per = (mode_r != CPM_SLEEP) && div_tick[1]; // R5 R7
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_r <= CLK_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_en_r <= '1;
    end else begin
      periph_en_r <= {NP{en_nxt.per}} & periph_clk_on; // R3
    end
  end

  cpm_clk_gate u_core_gate (
    .clk(clk),
    .en(en_r.core),
    .gclk(cpu_core_clock)
  );

  cpm_clk_gate u_sys_gate (
    .clk(clk),
    .en(en_r.sys),
    .gclk(sys_bus_clock)
  );

  cpm_clk_gate u_per_gate (
    .clk(clk),
    .en(en_r.per),
    .gclk(periph_bus_clock)
  );

  generate
    for (genvar p = 0; p < NP; p++) begin : g_periph
      cpm_clk_gate u_gate (
        .clk(clk),
        .en(periph_en_r[p]),
        .gclk(periph_clk[p])
      );
    end
  endgenerate

  assign mode_state = mode_r;
  assign clk_en = en_r;
  assign periph_en = periph_en_r;
  assign pll_bypass = pll_bypass_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_asleep_woken;
    (mode_r == CPM_SLEEP) && wake_sync_r;
  endsequence

  sequence s_back_running;
    (mode_r == CPM_NORMAL) ##1 en_r.core;
  endsequence

  a_normal_core_on: assert property ((mode_r == CPM_NORMAL) |=> en_r.core) // R2
    else $error("core clock gated in normal mode");
  a_periph_mask_off: assert property (!periph_clk_on[0] |=> !periph_en_r[0]) // R3
    else $error("masked peripheral clock still enabled");
  a_slow_core_tick: assert property ((mode_r == CPM_SLOW) |=> (en_r.core == $past(slow_tick)) && pll_bypass_r) // R4
    else $error("slow mode core clock not from slow divider");
  a_idle_core_stop: assert property ((mode_r == CPM_IDLE) |=> !en_r.core) // R5
    else $error("core clock runs in idle");
  a_idle_bus_run: assert property ((mode_r == CPM_IDLE) && div_tick[0] && div_tick[1] |=> en_r.sys && en_r.per) // R5
    else $error("bus clock stopped in idle");
  a_irq_wakes_core: assert property ((mode_r == CPM_IDLE) && cpu_irq |=> s_back_running) // R6
    else $error("interrupt did not wake core");
  a_sleep_all_off: assert property ((mode_r == CPM_SLEEP) |=> !en_r.sys && !en_r.per && (periph_en_r == '0)) // R7
    else $error("clock running in sleep");
  a_mode_hold_nowr: assert property ((mode_r == CPM_NORMAL) && !mode_wr |=> mode_r == CPM_NORMAL) // R8
    else $error("mode left normal without a write");
  a_sleep_wake_back: assert property (s_asleep_woken |=> s_back_running) // R8
    else $error("wake event did not leave sleep");

endmodule

// ==== core/cpm_pkg.sv ====
// Function
// R1: Core, system bus and peripheral bus clocks all come from the one on-chip phase-locked loop clock.
// R2: Normal mode clocks the core and every peripheral except those that software has switched off.
// R3: Software can switch the clock of each peripheral on or off on its own.
// R4: Slow mode makes the core clock from the slow clock setting, with the phase-locked loop bypassed.
// R5: Idle mode stops only the core clock and keeps all peripheral clocks running; the code keeps only peripherals set in periph_clk_on running.
// R6: In idle mode, any interrupt request to the core restores the core clock.
// R7: Sleep mode stops every clock except the one that feeds the wake-up logic.
// R8: Low-power modes are entered only by a mode write, and a wake event returns the block to normal mode.
package cpm_pkg;

  localparam int SLOW_W = 8;
  localparam int DIV_W = 4;
  localparam int NUM_PERIPH = 8;

  // divider reload values: a clock pulse every (value + 1) cycles
  localparam logic [DIV_W-1:0] SYS_DIV_DEF = 4'h0;
  localparam logic [DIV_W-1:0] PER_DIV_DEF = 4'h1;
  localparam logic [DIV_W-1:0] DIV_CNT_RST = 4'h0;
  localparam logic [SLOW_W-1:0] SLOW_CNT_RST = 8'h00;

  typedef enum logic [1:0] {
    CPM_NORMAL = 2'b00,
    CPM_SLOW = 2'b01,
    CPM_IDLE = 2'b10,
    CPM_SLEEP = 2'b11
  } cpm_mode_t;

  typedef struct packed {
    logic core;
    logic sys;
    logic per;
  } cpm_clk_en_t;

  localparam cpm_mode_t MODE_RST = CPM_NORMAL;
  localparam cpm_clk_en_t CLK_EN_RST = '{core: 1'h1, sys: 1'h1, per: 1'h1};

endpackage

// ==== core/cpm_clk_gate.sv ====
`timescale 1ns/10ps
module cpm_clk_gate (
  // clock in
  input wire logic clk,
  // gate control
  input wire logic en,
  // gated clock
  output logic gclk
);

  logic en_lat;

  // enable only changes while clk is low, so gclk never glitches
  always_latch begin
    if (!clk) begin
      en_lat <= en;
    end
  end

  assign gclk = clk & en_lat;

endmodule

// ==== verif/cpm_power_manager_bench.sv ====
`timescale 1ns/10ps
module cpm_power_manager_bench;
  import cpm_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic mode_wr = 1'h0;
  logic cpu_irq = 1'h0;
  logic wake_evt = 1'h0;
  cpm_mode_t mode_sel = CPM_NORMAL;
  logic [SLOW_W-1:0] slow_clock_setting = 8'h00;
  logic [SLOW_W-1:0] s;
  logic [NUM_PERIPH-1:0] periph_clk_on = 8'hff;
  logic [NUM_PERIPH-1:0] periph_clk, periph_en, seen, seen_clk;
  logic [2:0] clk_seen;
  logic cpu_core_clock, sys_bus_clock, periph_bus_clock, pll_bypass;
  cpm_mode_t mode_state;
  cpm_clk_en_t clk_en;
  int fail_count = 0;
  int n_tests = 0;
  int gap;
  `define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %0t %s", $time, m); end end

  always #2 clk = ~clk;

  cpm_power_manager uut (.clk(clk), .rstn(rstn), .mode_wr(mode_wr), .mode_sel(mode_sel),
    .slow_clock_setting(slow_clock_setting), .periph_clk_on(periph_clk_on), .cpu_irq(cpu_irq),
    .wake_evt(wake_evt), .cpu_core_clock(cpu_core_clock), .sys_bus_clock(sys_bus_clock),
    .periph_bus_clock(periph_bus_clock), .periph_clk(periph_clk), .mode_state(mode_state),
    .clk_en(clk_en), .periph_en(periph_en), .pll_bypass(pll_bypass));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle write strobe, then let mode and gate enables settle
  task automatic wr(input cpm_mode_t m);
    mode_sel = m;
    mode_wr = 1'h1;
    step(1);
    mode_wr = 1'h0;
    step(3);
  endtask

  // peripheral enables pulse with the bus tick, so collect them over a few cycles
  // gated clocks are sampled in the high phase, so a set bit means that clock pulsed
  task automatic scan();
    seen = 8'h00;
    seen_clk = 8'h00;
    clk_seen = 3'h0;
    repeat (4) begin
      seen = seen | periph_en;
      seen_clk = seen_clk | periph_clk;
      clk_seen = clk_seen | {cpu_core_clock, sys_bus_clock, periph_bus_clock};
      step(1);
    end
  endtask

  function automatic int slow_gap(input logic [SLOW_W-1:0] v);
    return int'(v) + 1;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(62));
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    `CHK(mode_state, CPM_NORMAL, "mode after reset")
    `CHK(pll_bypass, 1'h0, "bypass after reset")
    for (int k = 0; k < 4; k++) begin
      // first pass is a fixed mask with peripheral 0 switched off
      periph_clk_on = (k == 0) ? 8'h5a : NUM_PERIPH'($urandom);
      step(2);
      scan();
      `CHK(seen, periph_clk_on, "peripheral gates in normal")
      `CHK(seen_clk, periph_clk_on, "peripheral clocks in normal")
      `CHK(clk_seen, 3'h7, "core and bus clocks in normal")
      `CHK(clk_en.core, 1'h1, "core gate in normal")
    end
    wr(CPM_IDLE);
    `CHK(mode_state, CPM_IDLE, "idle entry")
    `CHK(clk_en.core, 1'h0, "core runs in idle")
    scan();
    `CHK(seen, periph_clk_on, "peripherals stopped in idle")
    `CHK(seen_clk, periph_clk_on, "peripheral clocks in idle")
    `CHK(clk_seen, 3'h3, "core or bus clocks wrong in idle")
    wr(CPM_SLOW);
    `CHK(mode_state, CPM_IDLE, "write taken in idle")
    cpu_irq = 1'h1;
    step(1);
    cpu_irq = 1'h0;
    step(2);
    `CHK(mode_state, CPM_NORMAL, "irq wake mode")
    `CHK(clk_en.core, 1'h1, "irq wake core gate")
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'h05 : 8'(2 + $urandom % 6);
      slow_clock_setting = s;
      wr(CPM_SLOW);
      `CHK(pll_bypass, 1'h1, "bypass in slow")
      gap = 0;
      while (clk_en.core !== 1'h1 && gap < 40) begin
        step(1);
        gap++;
      end
      step(1);
      gap = 1;
      while (clk_en.core !== 1'h1 && gap < 40) begin
        step(1);
        gap++;
      end
      `CHK(gap, slow_gap(s), "slow core period")
      wr(CPM_NORMAL);
      `CHK(pll_bypass, 1'h0, "bypass after slow")
    end
    periph_clk_on = 8'hff;
    wr(CPM_SLEEP);
    `CHK(clk_en, 3'h0, "gates in sleep")
    scan();
    `CHK(seen, 8'h00, "peripherals in sleep")
    `CHK(seen_clk, 8'h00, "peripheral clocks in sleep")
    `CHK(clk_seen, 3'h0, "core or bus clocks in sleep")
    cpu_irq = 1'h1;
    step(3);
    cpu_irq = 1'h0;
    `CHK(mode_state, CPM_SLEEP, "irq woke sleep")
    wake_evt = 1'h1;
    step(4);
    wake_evt = 1'h0;
    step(3);
    `CHK(mode_state, CPM_NORMAL, "wake from sleep")
    `CHK(clk_en.core, 1'h1, "core after wake")
    summarize();
  end

  initial begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule
